//--- src/hpm_pkg.sv
// Constants and types shared by the host parallel memory port
package hpm_pkg;
   localparam int DW = 16;
   localparam int AW = 16;
   // CPU-side register indices; byte address is four times the index
   localparam logic [15:0] IDX_EMU   = 16'hA002;
   localparam logic [15:0] IDX_CTRL  = 16'hA018;
   localparam logic [15:0] IDX_WADDR = 16'hA01A;
   localparam logic [15:0] IDX_RADDR = 16'hA01C;
   // Control register bit positions
   localparam int CTL_TOCORE = 1;
   localparam int CTL_TOHOST = 2;
   localparam int CTL_RDY    = 3;
   localparam int CTL_DUAL   = 8;
   localparam int CTL_WSEL   = 9;
   // Reset values
   localparam logic [15:0] CTL_RST  = 16'h0000;
   localparam logic [1:0]  EMU_RST  = 2'h0;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   // Word ranges: the core register window and reachable spans
   localparam logic [15:0] MMR_TOP    = 16'h005F;
   localparam logic [15:0] SPAN_SMALL = 16'h4000;
   localparam logic [15:0] SPAN_LARGE = 16'h8000;
   localparam int FIFO_DEPTH = 8;
   // Host access selects, in pin encoding order
   typedef enum logic [1:0] {
      SEL_CTRL, SEL_DATA_INC, SEL_ADDR, SEL_DATA_FIX
   } hpm_sel_t;
   // Synchronised host control pins
   typedef struct packed {
      logic     strobe_n;
      logic     half;
      logic     rnw;
      hpm_sel_t sel;
   } hpm_ctl_t;
   // Write FIFO entry
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
   } hpm_word_t;
endpackage : hpm_pkg

//--- src/hpm_port.sv
// Host parallel memory port: host pins, transfer logic and APB registers
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module hpm_port #(
   parameter bit WIDE  = 1'b1,
   parameter int DEPTH = hpm_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave for the core
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [19:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Host pins
   input  wire logic                 mode_strap_pin,
   input  wire logic                 host_strobe_n,
   input  wire logic                 host_half_sel,
   input  wire logic                 read_write_sel,
   input  wire logic [1:0]           access_select,
   input  wire logic [hpm_pkg::AW-1:0] host_addr_bus,
   input  wire logic [hpm_pkg::DW-1:0] host_data_in,
   output logic      [hpm_pkg::DW-1:0] host_data_out,
   output logic                      host_data_oe,
   output logic                      host_ready_out,
   output logic                      host_int_n,
   // Core side
   output logic                      core_int,
   output logic      [1:0]           emu_mode,
   // Internal memory port
   output logic                      mem_req,
   output logic                      mem_we,
   output logic      [hpm_pkg::AW-1:0] mem_addr,
   output logic      [hpm_pkg::DW-1:0] mem_wdata,
   input  wire logic [hpm_pkg::DW-1:0] mem_rdata,
   input  wire logic                 mem_ack
);
   import hpm_pkg::*;
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
   localparam logic [PW:0] ONE_C   = (PW+1)'(1);

   typedef enum logic [1:0] {X_IDLE, X_WR, X_RD} hpm_xfer_t;

   // Reachable word check, used by both transfer directions
   function automatic logic legal(input logic [AW-1:0] a);
      logic [AW-1:0] span;
      span = WIDE ? SPAN_LARGE : SPAN_SMALL;
      return (a > MMR_TOP) && (a < span);
   endfunction : legal

   hpm_ctl_t  ctl_s1, ctl_s2, ctl_s3, cyc;
   hpm_xfer_t xs;
   logic            strap_done, mux_mode;
   logic [15:0]     ctrl, write_addr_reg, read_addr_reg, rd_ptr;
   logic [7:0]      lo_byte;
   logic [15:0]     rd_word, wr_data;
   logic [AW-1:0]   cyc_addr;
   logic            pend_rd, pend_wr, rd_inc, rd_drop;
   hpm_word_t       wf_mem [DEPTH];
   logic [15:0]     rf_mem [DEPTH];
   logic [PW-1:0]   wf_rp, wf_wp, rf_rp, rf_wp;
   logic [PW:0]     wf_cnt, rf_cnt, wr_lim;
   logic            start, stop, last, is_data, wf_push, wf_pop;
   logic            rf_push, rf_pop, rf_flush, fetch_ok;
   logic            apb_wr, host_ctl_wr, core_ctl_wr;
   logic [15:0]     apb_idx, next_word, next_rd;

   // Two-stage synchroniser plus an edge stage; only s2 reads s1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_s1 <= '{1'b1, 1'b0, 1'b0, SEL_CTRL};
         ctl_s2 <= '{1'b1, 1'b0, 1'b0, SEL_CTRL};
         ctl_s3 <= '{1'b1, 1'b0, 1'b0, SEL_CTRL};
      end else begin
         ctl_s1 <= '{host_strobe_n, host_half_sel, read_write_sel,
                     hpm_sel_t'(access_select)};
         ctl_s2 <= ctl_s1;
         ctl_s3 <= ctl_s2;
      end
   end

   // Strobe edges and the current access kind
   assign start   = ctl_s3.strobe_n & ~ctl_s2.strobe_n;
   assign stop    = ~ctl_s3.strobe_n & ctl_s2.strobe_n;
   assign is_data = ctl_s2.sel inside {SEL_DATA_INC, SEL_DATA_FIX};
   // Multiplexed cycles complete on the second byte
   assign last    = !mux_mode || ctl_s2.half;
   assign next_word = mux_mode ? {host_data_in[7:0], lo_byte}
                               : host_data_in;

   // Strap is caught on the first clock after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done <= 1'b0;
         mux_mode   <= 1'b1;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         mux_mode   <= mode_strap_pin | ~WIDE;
      end
   end

   // Holds the first byte and the current cycle's controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_byte  <= 8'h00;
         cyc      <= '{1'b1, 1'b0, 1'b0, SEL_CTRL};
         cyc_addr <= ADDR_RST;
      end else if (start) begin
         cyc      <= ctl_s2;
         cyc_addr <= host_addr_bus;
         if (mux_mode && !ctl_s2.half)
            lo_byte <= host_data_in[7:0];
      end
   end

   // APB decode: index is the byte address divided by four
   assign apb_idx = paddr[17:2];
   assign apb_wr  = psel & penable & pready & pwrite;
   assign host_ctl_wr = start & last & ~ctl_s2.rnw
                        & (ctl_s2.sel == SEL_CTRL);
   assign core_ctl_wr = apb_wr & (apb_idx == IDX_CTRL);

   // Control register: each side sets the other's flag; set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTL_RST;
      end else begin
         if (host_ctl_wr) begin
            ctrl[CTL_DUAL] <= next_word[CTL_DUAL];
            ctrl[CTL_WSEL] <= next_word[CTL_WSEL];
         end
         if (host_ctl_wr && next_word[CTL_TOCORE])
            ctrl[CTL_TOCORE] <= 1'b1;
         else if (core_ctl_wr && pwdata[CTL_TOCORE])
            ctrl[CTL_TOCORE] <= 1'b0;
         if (core_ctl_wr && pwdata[CTL_TOHOST])
            ctrl[CTL_TOHOST] <= 1'b1;
         else if (host_ctl_wr && next_word[CTL_TOHOST])
            ctrl[CTL_TOHOST] <= 1'b0;
      end
   end

   // Address registers: single mode writes both, dual mode picks one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_addr_reg <= ADDR_RST;
         read_addr_reg  <= ADDR_RST;
      end else if (mux_mode) begin
         if (start && last && !ctl_s2.rnw && ctl_s2.sel == SEL_ADDR) begin
            if (!ctrl[CTL_DUAL] || ctrl[CTL_WSEL])
               write_addr_reg <= next_word;
            if (!ctrl[CTL_DUAL] || !ctrl[CTL_WSEL])
               read_addr_reg <= next_word;
         end else if (wf_push && ctl_s2.sel == SEL_DATA_INC) begin
            write_addr_reg <= write_addr_reg + 16'h0001;
         end
      end
   end

   // Write path: a full FIFO holds the word back and stalls the host
   assign wr_lim  = (cyc.sel == SEL_DATA_INC) ? DEPTH_C : ONE_C;
   assign wf_push = (start && last && !ctl_s2.rnw && is_data
                     && (wf_cnt < ((ctl_s2.sel == SEL_DATA_INC)
                                   ? DEPTH_C : ONE_C)))
                    || (pend_wr && wf_cnt < wr_lim);
   assign wf_pop  = (xs == X_WR && mem_ack)
                    || (xs == X_IDLE && wf_cnt != '0
                        && !legal(wf_mem[wf_rp].addr));

   // Write FIFO storage and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wf_wp   <= '0;
         wf_rp   <= '0;
         wf_cnt  <= '0;
         pend_wr <= 1'b0;
         wr_data <= 16'h0000;
      end else begin
         if (start && last && !ctl_s2.rnw && is_data) begin
            wr_data <= next_word;
            pend_wr <= !wf_push;
         end else if (wf_push) begin
            pend_wr <= 1'b0;
         end
         if (wf_push) begin
            wf_mem[wf_wp] <= '{
               mux_mode ? write_addr_reg
                        : (start ? host_addr_bus : cyc_addr),
               pend_wr ? wr_data : next_word};
            wf_wp <= wf_wp + 1'b1;
         end
         if (wf_pop)
            wf_rp <= wf_rp + 1'b1;
         wf_cnt <= wf_cnt + (PW+1)'(wf_push) - (PW+1)'(wf_pop);
      end
   end

   // Read path: a data read with an empty FIFO waits for a fetch
   assign rf_pop   = stop && cyc.rnw && last
                     && (cyc.sel inside {SEL_DATA_INC, SEL_DATA_FIX});
   // New read address or fixed-address data read discards stale words
   assign rf_flush = (mux_mode && start && last && !ctl_s2.rnw
                      && ctl_s2.sel == SEL_ADDR)
                     || (!mux_mode && start && ctl_s2.rnw && is_data
                         && !(rd_inc && rf_cnt != '0))
                     || (rf_pop && cyc.sel == SEL_DATA_FIX);
   assign fetch_ok = (wf_cnt == '0) && !rf_flush
                     && ((pend_rd && rf_cnt == '0)
                         || (rd_inc && rf_cnt < DEPTH_C - ONE_C));
   assign rf_push  = (xs == X_RD && mem_ack && !rd_drop)
                     || (xs == X_IDLE && fetch_ok && !legal(rd_ptr));
   assign next_rd  = (xs == X_RD) ? mem_rdata : 16'h0000;

   // Read pointer and read FIFO storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ptr <= ADDR_RST;
         rf_wp  <= '0;
         rf_rp  <= '0;
         rf_cnt <= '0;
         rd_inc <= 1'b0;
      end else begin
         if (rf_flush) begin
            rf_wp  <= '0;
            rf_rp  <= '0;
            rf_cnt <= '0;
            rd_inc <= 1'b0;
            // Fixed reads rewind over all fetched words, the one just handed over included
            rd_ptr <= !mux_mode ? host_addr_bus
                      : (start && ctl_s2.sel == SEL_ADDR) ? next_word
                      : rd_ptr - 16'(rf_cnt)
                        - 16'(xs == X_RD);
         end else begin
            if (rf_push) begin
               rf_mem[rf_wp] <= next_rd;
               rf_wp <= rf_wp + 1'b1;
            end
            if (rf_pop)
               rf_rp <= rf_rp + 1'b1;
            rf_cnt <= rf_cnt + (PW+1)'(rf_push) - (PW+1)'(rf_pop);
         end
         // A flushing start still records the burst kind for prefetch
         if (start && ctl_s2.rnw && is_data)
            rd_inc <= (ctl_s2.sel == SEL_DATA_INC);
         if (xs == X_IDLE && fetch_ok)
            rd_ptr <= rd_ptr + 16'h0001;
      end
   end

   // Transfer engine: writes drain before any read is fetched
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xs        <= X_IDLE;
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= ADDR_RST;
         mem_wdata <= 16'h0000;
         rd_drop   <= 1'b0;
      end else begin
         unique case (xs)
            X_IDLE: begin
               rd_drop <= 1'b0;
               if (wf_cnt != '0 && legal(wf_mem[wf_rp].addr)) begin
                  xs        <= X_WR;
                  mem_req   <= 1'b1;
                  mem_we    <= 1'b1;
                  mem_addr  <= wf_mem[wf_rp].addr;
                  mem_wdata <= wf_mem[wf_rp].data;
               end else if (wf_cnt == '0 && fetch_ok
                            && legal(rd_ptr)) begin
                  xs       <= X_RD;
                  mem_req  <= 1'b1;
                  mem_we   <= 1'b0;
                  mem_addr <= rd_ptr;
               end
            end
            X_WR, X_RD: begin
               if (rf_flush)
                  rd_drop <= 1'b1;
               if (mem_ack) begin
                  xs      <= X_IDLE;
                  mem_req <= 1'b0;
                  mem_we  <= 1'b0;
               end
            end
         endcase
      end
   end

   // Host read data, output enable and ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_rd        <= 1'b0;
         rd_word        <= 16'h0000;
         host_data_out  <= 16'h0000;
         host_data_oe   <= 1'b0;
         host_ready_out <= 1'b1;
      end else begin
         if (start && ctl_s2.rnw) begin
            unique case (ctl_s2.sel)
               SEL_CTRL: rd_word <= ctrl
                  | (16'h0001 << CTL_RDY);
               SEL_ADDR: rd_word <= (ctrl[CTL_DUAL] && ctrl[CTL_WSEL])
                  ? write_addr_reg : read_addr_reg;
               SEL_DATA_INC, SEL_DATA_FIX: ;
            endcase
            pend_rd <= is_data && (!mux_mode || !ctl_s2.half);
            host_data_oe <= !is_data || (mux_mode && ctl_s2.half);
         end else if (pend_rd && rf_cnt != '0 && !rf_flush) begin
            rd_word      <= rf_mem[rf_rp];
            pend_rd      <= 1'b0;
            host_data_oe <= 1'b1;
         end else if (stop) begin
            host_data_oe <= 1'b0;
         end
         host_data_out <= !mux_mode ? rd_word
            : (cyc.half ? {8'h00, rd_word[15:8]}
                        : {8'h00, rd_word[7:0]});
         host_ready_out <= !(pend_rd || pend_wr);
      end
   end

   // Core APB slave: one wait state, errors on unmapped indices
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready   <= 1'b0;
         prdata   <= 32'h0000_0000;
         pslverr  <= 1'b0;
         emu_mode <= EMU_RST;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         if (psel && penable && !pready) begin
            unique case (apb_idx)
               IDX_EMU:   prdata <= {30'h0, emu_mode};
               IDX_CTRL:  prdata <= {16'h0000, ctrl
                             | (16'(host_ready_out) << CTL_RDY)};
               IDX_WADDR: prdata <= {16'h0000, write_addr_reg};
               IDX_RADDR: prdata <= {16'h0000, read_addr_reg};
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (apb_wr && apb_idx == IDX_EMU)
            emu_mode <= pwdata[1:0];
      end
   end

   // Interrupt lines follow the control register flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_int   <= 1'b0;
         host_int_n <= 1'b1;
      end else begin
         core_int   <= ctrl[CTL_TOCORE];
         host_int_n <= ~ctrl[CTL_TOHOST];
      end
   end

   property p_mem_legal;
      @(posedge pclk) disable iff (!presetn)
      mem_req |-> mem_addr > MMR_TOP;
   endproperty
   a_mem_legal: assert property (p_mem_legal)
      else $error("protected word reached");

   property p_mem_span;
      @(posedge pclk) disable iff (!presetn)
      mem_req |-> mem_addr < (WIDE ? SPAN_LARGE : SPAN_SMALL);
   endproperty
   a_mem_span: assert property (p_mem_span)
      else $error("word beyond reachable span");

   property p_strap;
      @(posedge pclk) disable iff (!presetn)
      $rose(strap_done) |-> mux_mode == ($past(mode_strap_pin) | ~WIDE);
   endproperty
   a_strap: assert property (p_strap)
      else $error("mode differs from strap");

   property p_busy_ready;
      @(posedge pclk) disable iff (!presetn)
      (pend_wr || pend_rd) ##1 (pend_wr || pend_rd) |-> !host_ready_out;
   endproperty
   a_busy_ready: assert property (p_busy_ready)
      else $error("ready high while busy");

   property p_nonmux_regs;
      @(posedge pclk) disable iff (!presetn)
      strap_done && !mux_mode |=> $stable(write_addr_reg)
                                  && $stable(read_addr_reg);
   endproperty
   a_nonmux_regs: assert property (p_nonmux_regs)
      else $error("address register moved in nonmultiplexed mode");

   property p_wr_hold;
      @(posedge pclk) disable iff (!presetn)
      mem_req && mem_we && !mem_ack |=> mem_req && $stable(mem_wdata)
                                        && $stable(mem_addr);
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write word dropped before acknowledge");

   property p_core_clear;
      @(posedge pclk) disable iff (!presetn)
      core_ctl_wr && pwdata[CTL_TOCORE] && !host_ctl_wr
      |=> ##1 !core_int;
   endproperty
   a_core_clear: assert property (p_core_clear)
      else $error("core clear did not drop core interrupt");

   property p_host_raise;
      @(posedge pclk) disable iff (!presetn)
      host_ctl_wr && next_word[CTL_TOCORE] |=> ##1 core_int;
   endproperty
   a_host_raise: assert property (p_host_raise)
      else $error("host request did not reach core");

   property p_apb_answer;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer late");

   property p_core_ro;
      @(posedge pclk) disable iff (!presetn)
      apb_wr && apb_idx == IDX_WADDR && !start && !wf_push
      |=> $stable(write_addr_reg);
   endproperty
   a_core_ro: assert property (p_core_ro)
      else $error("core wrote address register");

   property p_single_entry;
      @(posedge pclk) disable iff (!presetn)
      wf_push && !pend_wr && ctl_s2.sel == SEL_DATA_FIX |-> wf_cnt == '0;
   endproperty
   a_single_entry: assert property (p_single_entry)
      else $error("fixed-address write overfilled FIFO");
endmodule : hpm_port

//--- tb/hpm_host.sv
// Host bus master model for the parallel memory port
`timescale 1ns/100ps
module hpm_host (
   // Clock
   input  wire logic        pclk,
   // Port pins seen by the host
   input  wire logic [15:0] dout,
   input  wire logic        oe,
   input  wire logic        rdy,
   output logic             stb_n,
   output logic             half,
   output logic             rw,
   output logic [1:0]       sel,
   output logic [15:0]      addr,
   output logic [15:0]      din
);
   // Idle bus at time zero
   initial begin
      stb_n = 1'b1;
      half = 1'b0;
      rw = 1'b1;
      sel = 2'h0;
      addr = 16'h0000;
      din = 16'h0000;
   end

   // One strobe cycle (a byte in multiplexed mode); all qualifiers held until ready is seen
   task automatic xfer(input logic r, input logic [1:0] s,
                       input logic [15:0] a, input logic [15:0] d,
                       input logic h,
                       output logic [15:0] q, output logic w,
                       output logic to);
      int i;
      w = 1'b0;
      to = 1'b1;
      @(posedge pclk);
      stb_n <= 1'b0;
      rw    <= r;
      half  <= h;
      sel   <= s;
      addr  <= a;
      din   <= d;
      for (i = 0; i < 60; i++) begin
         @(posedge pclk);
         if (!rdy) w = 1'b1;
         if (i >= 4 && rdy && (!r || oe)) begin
            to = 1'b0;
            break;
         end
      end
      q = dout;
      stb_n <= 1'b1;
      // Released lines must not keep a stale value
      addr  <= ~a;
      din   <= ~d;
      repeat (5) @(posedge pclk);
   endtask : xfer
endmodule : hpm_host

//--- tb/hpm_port_tb.sv
// Self-checking bench for the host parallel memory port
`timescale 1ns/100ps
module hpm_port_tb;
   import hpm_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        mode_strap_pin, host_strobe_n, host_half_sel, read_write_sel;
   logic [1:0]  access_select, emu_mode;
   logic [15:0] host_addr_bus, host_data_in, host_data_out, q, d;
   logic        host_data_oe, host_ready_out, host_int_n, core_int, w, to;
   logic        mem_req, mem_we, mem_ack;
   logic [15:0] mem_addr, mem_wdata, mem_rdata;
   logic [64:0] ea[$];
   logic [64:0] e;
   logic [31:0] em[$];
   logic [15:0] wa[5] = '{16'h0060, 16'h7FFF, 16'h0100, 16'h005F, 16'h8000};
   int          num_errors, n_checks, dly, k;

   hpm_port #(.WIDE(1'b1), .DEPTH(4)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_strap_pin,
      .host_strobe_n, .host_half_sel, .read_write_sel, .access_select,
      .host_addr_bus, .host_data_in, .host_data_out, .host_data_oe,
      .host_ready_out, .host_int_n, .core_int, .emu_mode, .mem_req, .mem_we,
      .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
   hpm_host host (.pclk, .dout(host_data_out), .oe(host_data_oe),
      .rdy(host_ready_out), .stb_n(host_strobe_n), .half(host_half_sel),
      .rw(read_write_sel), .sel(access_select), .addr(host_addr_bus),
      .din(host_data_in));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input string n, input logic [47:0] x,
                      input logic [47:0] g);
      n_checks++;
      if (g !== x) begin
         num_errors++;
         $display("BAD %s exp %h got %h", n, x, g);
      end
   endtask : chk

   task automatic end_sim;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // APB master: setup, access, hold until pready at a rising edge
   task automatic apb(input logic wr, input logic [15:0] i,
                      input logic [31:0] v);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, i, 2'h0};
      pwdata  <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 20);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (!pready) begin
         num_errors++;
         end_sim();
      end
   endtask : apb

   // Note the expected read, then run it
   task automatic rd(input logic [15:0] i, input logic [32:0] x,
                     input logic [31:0] m);
      ea.push_back({m, x});
      apb(1'b0, i, 32'h0000_0000);
   endtask : rd

   task automatic hx(input logic r, input logic [1:0] s,
                     input logic [15:0] a, input logic [15:0] v,
                     input logic h = 1'b0);
      host.xfer(r, s, a, v, h, q, w, to);
      if (to) begin
         num_errors++;
         end_sim();
      end
   endtask : hx

   // Memory answers after a random wait; idle read lines keep changing
   always @(posedge pclk) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         if (dly == 0) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem_addr ^ 16'hA5A5;
            dly = 2 + $urandom_range(3);
         end else dly--;
      end
   end

   // Watcher: oldest note against each completed result
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = ea.pop_front();
         chk("apb", e[32:0] & {1'b1, e[64:33]}, {pslverr, prdata & e[64:33]});
      end
      if (mem_req && mem_ack) begin
         chk("mrange", 1, mem_addr > MMR_TOP && mem_addr < SPAN_LARGE);
         if (mem_we) chk("mwr", em.size() ? em.pop_front() : 'x,
                         {mem_addr, mem_wdata});
      end
   end

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 20'h00000;
      pwdata = 32'h0000_0000;
      mode_strap_pin = 1'b0;
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
      dly = 2;
      num_errors = 0;
      n_checks = 0;
      void'($urandom(32'h37E0E022));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      // Core side register access
      rd(IDX_CTRL, 33'h0, 32'hFFFF_FFF7);
      rd(IDX_EMU, {31'h0, EMU_RST}, 32'hFFFF_FFFF);
      apb(1'b1, IDX_EMU, 32'h0000_0003);
      rd(IDX_EMU, 33'h3, 32'hFFFF_FFFF);
      chk("emu_mode", 3, emu_mode);
      apb(1'b1, IDX_WADDR, 32'h0000_1234);
      rd(IDX_WADDR, {17'h0, ADDR_RST}, 32'hFFFF_FFFF);
      rd(16'h0100, 33'h1_0000_0000, 32'hFFFF_FFFF);
      // Interrupts in both directions
      hx(1'b0, 2'h0, 16'h0000, 16'h0002);
      chk("core_int", 1, core_int);
      rd(IDX_CTRL, 33'h2, 32'h0000_0006);
      apb(1'b1, IDX_CTRL, 32'h0000_0002);
      repeat (2) @(posedge pclk);
      chk("core_int", 0, core_int);
      apb(1'b1, IDX_CTRL, 32'h0000_0004);
      repeat (2) @(posedge pclk);
      chk("host_int_n", 0, host_int_n);
      hx(1'b1, 2'h0, 16'h0000, 16'h0000);
      chk("host_ctrl", 16'h0004, q & 16'h0006);
      hx(1'b0, 2'h0, 16'h0000, 16'h0004);
      chk("host_int_n", 1, host_int_n);
      // Data writes at edges of the reachable span, then reads back
      foreach (wa[i]) begin
         d = 16'($urandom);
         if (wa[i] > MMR_TOP && wa[i] < SPAN_LARGE) em.push_back({wa[i], d});
         hx(1'b0, 2'h3, wa[i], d);
      end
      foreach (wa[i]) begin
         hx(1'b1, 2'h3, wa[i], 16'h0000);
         if (wa[i] > MMR_TOP && wa[i] < SPAN_LARGE) begin
            chk("host_rd", wa[i] ^ 16'hA5A5, q);
            chk("wait", 1, w);
         end else chk("host_rd", 0, q);
      end
      // Second reset with the strap high: multiplexed byte pairs
      presetn        <= 1'b0;
      mode_strap_pin <= 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      d = 16'($urandom);
      em.push_back({16'h3C5A, d});
      hx(1'b0, 2'h2, 16'h0000, 16'h005A, 1'b0);
      hx(1'b0, 2'h2, 16'h0000, 16'h003C, 1'b1);
      hx(1'b0, 2'h3, 16'h0000, {8'h00, d[7:0]}, 1'b0);
      hx(1'b0, 2'h3, 16'h0000, {8'h00, d[15:8]}, 1'b1);
      rd(IDX_RADDR, 33'h3C5A, 32'hFFFF_FFFF);
      apb(1'b1, IDX_WADDR, 32'h0000_0000);
      rd(IDX_WADDR, 33'h3C5A, 32'hFFFF_FFFF);
      // Two fixed reads of one word must both return that word
      for (k = 0; k < 4; k++) begin
         hx(1'b1, 2'h3, 16'h0000, 16'h0000, k[0]);
         chk("mux_rd", k[0] ? 16'h0099 : 16'h00FF, q);
      end
      for (k = 0; k < 50 && em.size() > 0; k++) @(posedge pclk);
      chk("drain", 0, em.size());
      end_sim();
   end
endmodule : hpm_port_tb
